// ===== hdl/six_port_io_config.sv
// Six 8-bit I/O ports with mode decode, four external interrupt groups and
// a classic Wishbone register slave. Pad inputs are synchronous to clk_i;
// pads resolve level from out, oe and pull_up outside this block.
//
// What this block does
// - Standard pins: direction/option pick four modes
// - Pull-up irq pins: dir0 opt1 pull-up interrupt
// - No-pull irq pins: dir0 opt1 floating interrupt
// - CAN pin never general output; else pull-up
// - CAN pin data readable even when direction 1
// - CAN transmit selected drives push-pull
// - Interrupt pins map onto four fixed groups
// - Wait leaves pins alone; interrupt wakes
// - Halt leaves pins alone; interrupt wakes
// - Interrupt needs irq mode and cleared mask
// - CPU requests: no event flag, enabled by direction/option only
// - Data, direction, option per port; reset zero
// - Bit n controls pin n of port
// - Input data read returns pin level
// - Output writes drive latch; read returns latch
// - Request latch hidden, cleared on vector fetch
//
// Chosen here: the Wishbone slave port.
`timescale 1ns/10ps
// Register map, one byte register per 32-bit word:
//   index 0x00..0x11  data, direction, option of ports A..F in turn
//   index 0x12        sticky group status, write one to clear
//   index 0x13        group mask for irq_o
//   anything else     reads zero, writes ignored
// Pad encoding per pin, registered so pads move one edge after a write:
//   push-pull   oe 1, out from the data latch
//   open-drain  out 0, oe high while the latch holds 0
//   input       oe 0, pull_up from the option bit where a pull-up exists
// Interrupt path: a falling edge on a pin in interrupt-input mode sets
// the hidden group latch and the sticky status bit on the next edge.
// The latch is cleared only by a vector fetch pulse and is never read;
// the status register is a separate software view with its own clear.
// Limitations the user must know:
//   edge sensitivity is fixed to falling; there is no sensitivity select
//   the global CPU mask gates the request lines, never the latch, so a
//   request taken while masked appears as soon as the mask is cleared
//   mode changes outside the safe sequence can raise spurious requests
// Bus timing, classic Wishbone single cycle:
//   edge 0  master raises cyc, stb, we, adr and data
//   edge 1  ack_o rises; read data is already on dat_o
//   edge 2  a write lands in its register; ack_o falls
//   the request must drop after the ack edge; a request held on
//   past that edge is seen as a new one and acked again
// Pin numbering: pin n of port p is bit 8*p+n of every 48-bit bus,
// port A being 0 and port F being 5.
// Shared CAN pin: pin 4 of port C. With the CAN transmitter enabled it is
// a push-pull output fed from can_transmit_output_i; otherwise it is a
// pull-up input whatever its port bits say. Its data bit always reads the
// pin, so software sees the transmitted level while CAN is active.
// Low power: wait_mode_i and halt_mode_i never touch the pads; they only
// qualify wake_o, which rises while a group request is pending and the
// CPU mask is clear.
// Interrupt groups:
//   group a  all eight pins of port A
//   group b  pins 0 to 5 of port B
//   group c  pins 1 and 2 of port C
//   group d  pins 0, 1, 4, 6 and 7 of port D
// Reset: synchronous, active high; every register, the pads, ack_o and
// dat_o go to zero, and so do all request outputs.
module six_port_io_config
(
   input wire logic clk_i,
   input wire logic rst_i,
   // Classic Wishbone slave
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [7:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   // Pads
   input wire logic [47:0] pin_in_i,
   output six_port_io_pkg::pad_ctl_type pads_o,
   // CAN transmitter on the shared pin
   input wire logic can_enable_i,
   input wire logic can_transmit_output_i,
   // CPU side
   input wire logic cpu_irq_masked_i,
   input wire logic [3:0] vector_fetch_i,
   input wire logic wait_mode_i,
   input wire logic halt_mode_i,
   output logic ext_irq_group_a_o,
   output logic ext_irq_group_b_o,
   output logic ext_irq_group_c_o,
   output logic ext_irq_group_d_o,
   output logic wake_o,
   output logic irq_o
);

   // Port number of a port register index
   function automatic logic [2:0] reg_port(input logic [4:0] idx);
      logic [4:0] q;
      // Only used for indices up to 0x11, so three bits hold the result
      q = idx / 5'd3;
      reg_port = q[2:0];
   endfunction : reg_port

   // Data, direction or option for a port register index
   function automatic logic [1:0] reg_kind(input logic [4:0] idx);
      logic [4:0] r;
      r = idx % 5'd3;
      reg_kind = r[1:0];
   endfunction : reg_kind

   // Port register file, one byte per port and kind
   logic [5:0][7:0] port_data;
   logic [5:0][7:0] port_direction;
   logic [5:0][7:0] port_option;
   logic [5:0][7:0] next_port_data;
   logic [5:0][7:0] next_port_direction;
   logic [5:0][7:0] next_port_option;
   // Status and mask of the four groups
   logic [3:0] irq_status;
   logic [3:0] irq_mask;
   logic [3:0] next_irq_status;
   logic [3:0] next_irq_mask;
   logic [3:0] group_latch;
   logic [3:0] next_group_latch;
   // Pin levels one cycle back, for the falling edge detector
   logic [47:0] pin_prev;
   logic [31:0] next_dat;
   logic next_ack;
   six_port_io_pkg::pad_ctl_type next_pads;
   // Flat 48-bit views of the port registers, bit 8*p+n per pin
   logic [47:0] data_flat;
   logic [47:0] dir_flat;
   logic [47:0] opt_flat;
   logic [47:0] irq_select;
   logic [47:0] pin_event;
   logic [3:0] group_event;
   // Decoded bus access
   logic [4:0] reg_idx;
   logic [2:0] acc_port;
   logic [1:0] acc_kind;
   logic wr_stb;
   logic [7:0] read_back;

   assign data_flat = port_data;
   assign dir_flat = port_direction;
   assign opt_flat = port_option;
   assign reg_idx = adr_i[6:2];
   assign acc_port = reg_port(reg_idx);
   assign acc_kind = reg_kind(reg_idx);
   // A write takes effect on the edge at which ack is sampled high; gating with
   // ack_o writes once per ack; a request held too long is acked again and writes again
   assign wr_stb = cyc_i && stb_i && we_i && ack_o && sel_i[0] && (adr_i[7] == 1'b0);

   // Interrupt input mode: direction 0, option 1, on capable pins only
   assign irq_select = ~dir_flat & opt_flat & six_port_io_pkg::IRQ_CAPABLE;
   // Falling edge on a pin selected as interrupt input; pin_prev clears
   // to zero in reset, so leaving reset can never look like a fall
   assign pin_event = pin_prev & ~pin_in_i & irq_select;

   // Group requests are the OR of their pins; pins outside every group
   // are masked off here even if their mode bits say interrupt
   always_comb
   begin
      group_event[0] = |(pin_event & six_port_io_pkg::GROUP_A_PINS);
      group_event[1] = |(pin_event & six_port_io_pkg::GROUP_B_PINS);
      group_event[2] = |(pin_event & six_port_io_pkg::GROUP_C_PINS);
      group_event[3] = |(pin_event & six_port_io_pkg::GROUP_D_PINS);
   end

   // Pad drive per pin from direction, option and data latch.
   // Open drain lets the pin float high when the latch holds 1, so the
   // outside pull-up decides the level; the block never drives a 1 there.
   // The CAN pin override comes last so it beats any port setting.
   always_comb
   begin
      for (int i = 0; i < six_port_io_pkg::PIN_COUNT; i++)
      begin
         if (dir_flat[i] && opt_flat[i])
         begin
            next_pads.out[i] = data_flat[i];
            next_pads.oe[i] = 1'b1;
            next_pads.pull_up[i] = 1'b0;
         end
         else if (dir_flat[i])
         begin
            next_pads.out[i] = 1'b0;
            next_pads.oe[i] = ~data_flat[i];
            next_pads.pull_up[i] = 1'b0;
         end
         else
         begin
            next_pads.out[i] = 1'b0;
            next_pads.oe[i] = 1'b0;
            next_pads.pull_up[i] = opt_flat[i] & ~six_port_io_pkg::NO_PULL_UP[i];
         end
      end
      // Shared CAN pin overrides the port bits
      if (can_enable_i)
      begin
         next_pads.out[six_port_io_pkg::CAN_PIN] = can_transmit_output_i;
         next_pads.oe[six_port_io_pkg::CAN_PIN] = 1'b1;
         next_pads.pull_up[six_port_io_pkg::CAN_PIN] = 1'b0;
      end
      else
      begin
         next_pads.out[six_port_io_pkg::CAN_PIN] = 1'b0;
         next_pads.oe[six_port_io_pkg::CAN_PIN] = 1'b0;
         next_pads.pull_up[six_port_io_pkg::CAN_PIN] = 1'b1;
      end
   end

   // Pads registered; wait and halt inputs deliberately do not touch them.
   // Reset holds every pad undriven with no pull-up while rst_i is high; the
   // pull-up on the CAN pin appears on the first edge out of reset.
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         pads_o <= '0;
         pin_prev <= '0;
      end
      else
      begin
         pads_o <= next_pads;
         pin_prev <= pin_in_i;
      end
   end

   // Read value of the addressed register
   // Unmapped and upper-half addresses read zero
   always_comb
   begin
      read_back = 8'h00;
      if (reg_idx <= six_port_io_pkg::LAST_PORT_REG)
      begin
         case (acc_kind)
            six_port_io_pkg::KIND_DATA:
            begin
               for (int b = 0; b < 8; b++)
               begin
                  // Output reads the latch, input reads the pin
                  if (port_direction[acc_port][b])
                     read_back[b] = port_data[acc_port][b];
                  else
                     read_back[b] = pin_in_i[8 * acc_port + b];
               end
               if (acc_port == 3'd2)
                  read_back[4] = pin_in_i[six_port_io_pkg::CAN_PIN];
            end
            six_port_io_pkg::KIND_DIRECTION: read_back = port_direction[acc_port];
            six_port_io_pkg::KIND_OPTION: read_back = port_option[acc_port];
            default: read_back = 8'h00;
         endcase
      end
      else if (reg_idx == six_port_io_pkg::IRQ_STATUS)
         read_back = {4'h0, irq_status};
      else if (reg_idx == six_port_io_pkg::IRQ_MASK)
         read_back = {4'h0, irq_mask};
      else
         read_back = 8'h00;
      if (adr_i[7])
         read_back = 8'h00;
   end

   // Wishbone answer: ack one cycle after the request, dropped after one
   always_comb
   begin
      next_ack = cyc_i && stb_i && !ack_o;
      next_dat = dat_o;
      if (next_ack)
         next_dat = {24'h00_0000, read_back};
   end

   // Ack and read data registered; dat_o keeps the value of the last acked access, read or write
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         ack_o <= 1'b0;
         dat_o <= 32'h0000_0000;
      end
      else
      begin
         ack_o <= next_ack;
         dat_o <= next_dat;
      end
   end

   // Port register writes
   // Only byte lane 0 carries a register; other lanes are ignored
   always_comb
   begin
      next_port_data = port_data;
      next_port_direction = port_direction;
      next_port_option = port_option;
      if (wr_stb && (reg_idx <= six_port_io_pkg::LAST_PORT_REG))
      begin
         case (acc_kind)
            six_port_io_pkg::KIND_DATA: next_port_data[acc_port] = dat_i[7:0];
            six_port_io_pkg::KIND_DIRECTION: next_port_direction[acc_port] = dat_i[7:0];
            six_port_io_pkg::KIND_OPTION: next_port_option[acc_port] = dat_i[7:0];
            default: next_port_data = port_data;
         endcase
      end
   end

   // Port registers; a write lands on the edge at which ack is high
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         port_data <= {6{six_port_io_pkg::PORT_RESET}};
         port_direction <= {6{six_port_io_pkg::PORT_RESET}};
         port_option <= {6{six_port_io_pkg::PORT_RESET}};
      end
      else
      begin
         port_data <= next_port_data;
         port_direction <= next_port_direction;
         port_option <= next_port_option;
      end
   end

   // Hidden request latches and the sticky status with mask.
   // Status clear by software and a new event in one cycle: the event
   // wins, so no request is ever lost to a late clear.
   always_comb
   begin
      // Vector fetch clears; a new event in the same cycle wins
      next_group_latch = (group_latch & ~vector_fetch_i) | group_event;
      next_irq_mask = irq_mask;
      next_irq_status = irq_status;
      if (wr_stb && (reg_idx == six_port_io_pkg::IRQ_MASK))
         next_irq_mask = dat_i[3:0];
      if (wr_stb && (reg_idx == six_port_io_pkg::IRQ_STATUS))
         next_irq_status = irq_status & ~dat_i[3:0];
      next_irq_status = next_irq_status | group_event;
   end

   // Group latches, status and mask; all clear in reset
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         group_latch <= six_port_io_pkg::GROUP_RESET;
         irq_status <= six_port_io_pkg::GROUP_RESET;
         irq_mask <= six_port_io_pkg::GROUP_RESET;
      end
      else
      begin
         group_latch <= next_group_latch;
         irq_status <= next_irq_status;
         irq_mask <= next_irq_mask;
      end
   end

   // Requests to the CPU, gated by its global mask
   assign ext_irq_group_a_o = group_latch[0] & ~cpu_irq_masked_i;
   assign ext_irq_group_b_o = group_latch[1] & ~cpu_irq_masked_i;
   assign ext_irq_group_c_o = group_latch[2] & ~cpu_irq_masked_i;
   assign ext_irq_group_d_o = group_latch[3] & ~cpu_irq_masked_i;
   // Any pending request ends wait or halt while the CPU mask is clear
   assign wake_o = (wait_mode_i | halt_mode_i) & (|group_latch) & ~cpu_irq_masked_i;
   // Software-visible interrupt, independent of the CPU mask
   assign irq_o = |(irq_status & irq_mask);

endmodule : six_port_io_config

// ===== hdl/six_port_io_pkg.sv
// Constants, capability masks and types for the six-port I/O block.
// Assumes a 50 MHz system clock and a 32-bit classic Wishbone register bus.
package six_port_io_pkg;

   localparam int PORT_COUNT = 6;
   localparam int PIN_COUNT = 48;

   // Register indices; the byte address is four times the index
   localparam logic [4:0] PORT_A_DATA = 5'h00;
   localparam logic [4:0] PORT_A_DIRECTION = 5'h01;
   localparam logic [4:0] PORT_A_OPTION = 5'h02;
   localparam logic [4:0] PORT_B_DATA = 5'h03;
   localparam logic [4:0] PORT_B_DIRECTION = 5'h04;
   localparam logic [4:0] PORT_B_OPTION = 5'h05;
   localparam logic [4:0] PORT_C_DATA = 5'h06;
   localparam logic [4:0] PORT_C_DIRECTION = 5'h07;
   localparam logic [4:0] PORT_C_OPTION = 5'h08;
   localparam logic [4:0] PORT_D_DATA = 5'h09;
   localparam logic [4:0] PORT_D_DIRECTION = 5'h0a;
   localparam logic [4:0] PORT_D_OPTION = 5'h0b;
   localparam logic [4:0] PORT_E_DATA = 5'h0c;
   localparam logic [4:0] PORT_E_DIRECTION = 5'h0d;
   localparam logic [4:0] PORT_E_OPTION = 5'h0e;
   localparam logic [4:0] PORT_F_DATA = 5'h0f;
   localparam logic [4:0] PORT_F_DIRECTION = 5'h10;
   localparam logic [4:0] PORT_F_OPTION = 5'h11;
   localparam logic [4:0] IRQ_STATUS = 5'h12;
   localparam logic [4:0] IRQ_MASK = 5'h13;
   localparam logic [4:0] LAST_PORT_REG = PORT_F_OPTION;

   // Kind of a port register within its group of three
   localparam logic [1:0] KIND_DATA = 2'h0;
   localparam logic [1:0] KIND_DIRECTION = 2'h1;
   localparam logic [1:0] KIND_OPTION = 2'h2;

   localparam logic [7:0] PORT_RESET = 8'h00;
   localparam logic [3:0] GROUP_RESET = 4'h0;

   // Pin n of port p sits at bit 8*p+n of these masks
   localparam logic [47:0] IRQ_CAPABLE = 48'h0000_D306_3FFF;
   localparam logic [47:0] NO_PULL_UP = 48'h0000_9204_2AAA;
   localparam int CAN_PIN = 20;
   localparam logic [47:0] GROUP_A_PINS = 48'h0000_0000_00FF;
   localparam logic [47:0] GROUP_B_PINS = 48'h0000_0000_3F00;
   localparam logic [47:0] GROUP_C_PINS = 48'h0000_0006_0000;
   localparam logic [47:0] GROUP_D_PINS = 48'h0000_D300_0000;

   // Drive of all pads, one bit per pin
   typedef struct packed {
      logic [47:0] out;
      logic [47:0] oe;
      logic [47:0] pull_up;
   } pad_ctl_type;

endpackage : six_port_io_pkg

// ===== verif/six_port_io_config_assertions.sv
// Port checks for the six-port I/O block: bus answer, CAN pin, wake-up.
// Bound into the block; one clock, reset synchronous and active high.
`timescale 1ns/10ps
module six_port_io_config_assertions
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [7:0] adr_i,
   input wire logic [31:0] dat_o,
   input wire logic ack_o,
   input wire six_port_io_pkg::pad_ctl_type pads_o,
   input wire logic can_enable_i,
   input wire logic can_transmit_output_i,
   input wire logic cpu_irq_masked_i,
   input wire logic [3:0] vector_fetch_i,
   input wire logic wait_mode_i,
   input wire logic halt_mode_i,
   input wire logic ext_irq_group_a_o,
   input wire logic wake_o
);
   // All checks sample on the rising edge and sleep in reset
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   a_ack_pulse: assert property (ack_o |=> !ack_o)
      else $error("ack held longer than one cycle");
   a_ack_answer: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
      else $error("request not answered next cycle");
   a_unmapped_zero: assert property
      (cyc_i && stb_i && !we_i && adr_i[7] && !ack_o |=> dat_o == 32'h0000_0000)
      else $error("unmapped read not zero");
   a_can_drive: assert property (can_enable_i [*2] |->
      pads_o.oe[20] && pads_o.out[20] == $past(can_transmit_output_i))
      else $error("shared pin not push-pull from CAN");
   a_can_pull_up: assert property
      (!can_enable_i && !rst_i ##1 !can_enable_i |-> !pads_o.oe[20] && pads_o.pull_up[20])
      else $error("shared pin not a pull-up input");
   a_masked_quiet: assert property
      (cpu_irq_masked_i |-> !ext_irq_group_a_o && !wake_o)
      else $error("request passed a masked CPU");
   a_wake_mode: assert property (wake_o |-> wait_mode_i || halt_mode_i)
      else $error("wake outside low power");
   a_wake_cause: assert property
      ((wait_mode_i || halt_mode_i) && ext_irq_group_a_o |-> wake_o)
      else $error("request did not wake");
   a_latch_holds: assert property
      (ext_irq_group_a_o && !vector_fetch_i[0] ##1 !cpu_irq_masked_i |-> ext_irq_group_a_o)
      else $error("request lost without fetch");
endmodule : six_port_io_config_assertions

bind six_port_io_config six_port_io_config_assertions u_chk
(
   .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
   .adr_i(adr_i), .dat_o(dat_o), .ack_o(ack_o), .pads_o(pads_o),
   .can_enable_i(can_enable_i), .can_transmit_output_i(can_transmit_output_i),
   .cpu_irq_masked_i(cpu_irq_masked_i), .vector_fetch_i(vector_fetch_i),
   .wait_mode_i(wait_mode_i), .halt_mode_i(halt_mode_i),
   .ext_irq_group_a_o(ext_irq_group_a_o), .wake_o(wake_o)
);

// ===== verif/pad_world.sv
// Pad world: resolves each pin from the block's drive, outside drivers
// and pull-ups. Assumes pads_o as declared in the package.
`timescale 1ns/10ps
module pad_world
(
   input wire logic clk_i,
   input wire six_port_io_pkg::pad_ctl_type pads_i,
   input wire logic [47:0] ext_en_i,
   input wire logic [47:0] ext_val_i,
   output logic [47:0] pin_o
);
   logic [47:0] noise = 48'h5555_5555_5555;

   // Floating level flips each cycle so it never looks settled
   always_ff @(posedge clk_i)
      noise <= ~noise;

   // Block drive wins, then outside drivers, then the pull-up
   always_comb
      for (int i = 0; i < 48; i++)
         pin_o[i] = pads_i.oe[i] ? pads_i.out[i] : ext_en_i[i] ? ext_val_i[i] :
            pads_i.pull_up[i] | noise[i];
endmodule : pad_world

// ===== verif/test_six_port_io_config.sv
// Self-checking bench for the six-port I/O block.
// Wishbone master tasks and a pad world; one 50 MHz clock.
`timescale 1ns/10ps
module test_six_port_io_config;
   logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, ack, ga, gb, gc, gd, wake, irq;
   logic can_en = 0, can_tx = 0, masked = 0, wait_m = 0, halt_m = 0;
   logic [7:0] adr = 0, rd, pat;
   logic [31:0] wdat = 0, dat;
   logic [47:0] ext_val = '1, pin, exp_oe;
   logic [3:0] fetch = 0;
   six_port_io_pkg::pad_ctl_type pads, saved;
   int fails = 0, checks_done = 0;

   always #10 clk_i = ~clk_i;

   // Outside circuit drives every pin but the shared CAN pin
   pad_world u_pads (.clk_i(clk_i), .pads_i(pads), .ext_en_i(48'hFFFF_FFEF_FFFF),
      .ext_val_i(ext_val), .pin_o(pin));
   six_port_io_config u_dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb),
      .we_i(we), .adr_i(adr), .sel_i(4'hF), .dat_i(wdat), .dat_o(dat), .ack_o(ack),
      .pin_in_i(pin), .pads_o(pads), .can_enable_i(can_en), .can_transmit_output_i(can_tx),
      .cpu_irq_masked_i(masked), .vector_fetch_i(fetch), .wait_mode_i(wait_m),
      .halt_mode_i(halt_m), .ext_irq_group_a_o(ga), .ext_irq_group_b_o(gb),
      .ext_irq_group_c_o(gc), .ext_irq_group_d_o(gd), .wake_o(wake), .irq_o(irq));

   task chk(input string what, input logic [47:0] exp, input logic [47:0] seen);
      checks_done++;
      if (seen !== exp)
      begin
         fails++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk

   // One classic cycle, held until ack is sampled high
   task wb(input logic w, input logic [7:0] a, input logic [7:0] d);
      int n;
      n = 0;
      @(posedge clk_i);
      cyc <= 1;
      stb <= 1;
      we <= w;
      adr <= a;
      wdat <= {24'h0000_00, d};
      do
      begin
         @(posedge clk_i);
         n++;
      end
      while (ack !== 1'b1 && n < 20);
      rd = dat[7:0];
      cyc <= 0;
      stb <= 0;
      chk("ack", 1, ack);
   endtask : wb

   task rc(input logic [7:0] a, input logic [7:0] exp);
      wb(0, a, 8'h00);
      chk($sformatf("reg %h", a), exp, rd);
   endtask : rc

   task complete_run;
      $display("checks %0d mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : complete_run

   // Watchdog against a hung handshake
   initial
   begin
      repeat (6000) @(posedge clk_i);
      fails++;
      complete_run;
   end

   // Main sequence
   initial
   begin
      repeat (10) @(posedge clk_i);
      rst_i <= 0;
      for (int r = 0; r < 21; r++)
         rc(8'(r * 4), (r < 18 && r % 3 == 0) ? 8'hFF : 8'h00);
      wb(1, 8'h80, 8'hFF);
      rc(8'h80, 8'h00);
      for (int p = 0; p < 6; p++)
      begin
         pat = 8'h3C + 8'(p);
         wb(1, 8'(p * 12 + 4), 8'hFF);
         rc(8'(p * 12), (p == 2) ? 8'h10 : 8'h00);
         wb(1, 8'(p * 12), pat);
         wb(1, 8'(p * 12 + 8), 8'h0F);
         rc(8'(p * 12), (p == 2) ? (pat | 8'h10) : pat);
         rc(8'(p * 12 + 8), 8'h0F);
         exp_oe[p * 8 +: 8] = 8'h0F | ~pat;
      end
      exp_oe[20] = 1'b0;
      repeat (2) @(posedge clk_i);
      chk("drive enables", exp_oe, pads.oe);
      // Output, floating input, then interrupt input
      for (int p = 0; p < 6; p++)
      begin
         wb(1, 8'(p * 12 + 8), 8'h00);
         wb(1, 8'(p * 12 + 4), 8'h00);
         wb(1, 8'(p * 12 + 8), 8'hFF);
      end
      fetch <= 4'hF;
      repeat (2) @(posedge clk_i);
      fetch <= 4'h0;
      chk("pull-ups", ~six_port_io_pkg::NO_PULL_UP, pads.pull_up);
      // Pull each pin low in turn and see which group answers
      for (int i = 0; i < 48; i++)
      begin
         ext_val[i] <= 1'b0;
         repeat (3) @(posedge clk_i);
         chk("groups", six_port_io_pkg::IRQ_CAPABLE[i] ? 4'(1 << (i / 8)) : 4'h0,
            {gd, gc, gb, ga});
         ext_val[i] <= 1'b1;
         fetch <= 4'hF;
         @(posedge clk_i);
         fetch <= 4'h0;
      end
      rc(8'h48, 8'h0F);
      chk("irq unmasked", 0, irq);
      wb(1, 8'h4C, 8'h05);
      @(posedge clk_i);
      chk("irq set", 1, irq);
      wb(1, 8'h48, 8'h05);
      rc(8'h48, 8'h0A);
      chk("irq clear", 0, irq);
      // Masked CPU, then wake from wait and halt
      masked <= 1;
      ext_val[0] <= 1'b0;
      repeat (3) @(posedge clk_i);
      chk("masked group", 0, ga);
      saved = pads;
      masked <= 0;
      wait_m <= 1;
      repeat (2) @(posedge clk_i);
      chk("wake in wait", 2'b11, {ga, wake});
      wait_m <= 0;
      halt_m <= 1;
      repeat (2) @(posedge clk_i);
      chk("wake in halt", 1, wake);
      chk("pads held", 0, {47'h0, saved !== pads});
      fetch <= 4'h1;
      @(posedge clk_i);
      fetch <= 4'h0;
      @(posedge clk_i);
      chk("fetch clears", 0, {ga, wake});
      can_en <= 1;
      can_tx <= 1;
      repeat (2) @(posedge clk_i);
      chk("can high", 2'b11, {pads.oe[20], pads.out[20]});
      can_tx <= 0;
      repeat (2) @(posedge clk_i);
      chk("can low", 2'b10, {pads.oe[20], pads.out[20]});
      complete_run;
   end
endmodule : test_six_port_io_config
